// File: rtl/flash_seq_pkg.sv
package flash_seq_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Bus geometry and register locations.
	localparam int          ADDR_W      = 16;
	localparam int          DATA_W      = 8;
	localparam logic [15:0] CTRL_ADDR   = 16'hFE08;
	localparam logic [15:0] PROT_ADDR   = 16'hFE09;
	localparam logic [15:0] USER_HI     = 16'hFDFF;
	localparam logic [15:0] VEC_LO      = 16'hFFD0;
	localparam logic [15:0] WDOG_ADDR   = 16'hFFFF;

	////////////////////////////////////////////////////////////////////////////
	// Array geometry.
	localparam int          USER_BIG    = 4096;
	localparam int          USER_SMALL  = 1536;
	localparam int          VEC_BYTES   = 48;
	localparam int          PAGE_BYTES  = 64;
	localparam int          ROW_BYTES   = 32;
	localparam int          PROT_UNIT   = 64;

	////////////////////////////////////////////////////////////////////////////
	// Control register fields, reset values and fixed read bytes.
	localparam int          CTRL_PGM    = 0;
	localparam int          CTRL_ERASE  = 1;
	localparam int          CTRL_MASS   = 2;
	localparam int          CTRL_HV     = 3;
	localparam int          CTRL_READY  = 7;
	localparam logic [7:0]  CTRL_RESET  = 8'h00;
	localparam logic [7:0]  PROT_OPEN   = 8'hFF;
	localparam logic [7:0]  ERASED_BYTE = 8'hFF;
	localparam logic [7:0]  BUSY_BYTE   = 8'hFF;

	////////////////////////////////////////////////////////////////////////////
	// Timing at the bus clock.
	localparam int          CLK_MHZ     = 250;
	localparam int          RCV_NS      = 1000;
	localparam int          RCV_CYCLES  = (RCV_NS * CLK_MHZ) / 1000;

	////////////////////////////////////////////////////////////////////////////
	// Types.
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} bus_req_t;

	typedef enum logic [5:0] {
		ST_IDLE   = 6'b000001,
		ST_SELECT = 6'b000010,
		ST_PROTRD = 6'b000100,
		ST_LATCH  = 6'b001000,
		ST_HV     = 6'b010000,
		ST_RECOV  = 6'b100000
	} seq_state_t;

endpackage

// File: rtl/hold_timer.sv
`timescale 1ns/10ps
module hold_timer import flash_seq_pkg::*; #(
	parameter int CYCLES = RCV_CYCLES
) (
	// Clock, reset and enable.
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	// Start pulse and running level.
	input  wire logic start,
	output logic      busy
);

	localparam int CW = $clog2(CYCLES + 1);

	initial begin
		if (CYCLES < 1)
			$error("hold_timer needs at least one cycle");
	end

	logic [CW-1:0] cnt_q;

	// Counts down from the load value; busy covers exactly CYCLES enabled edges.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cnt_q <= '0;
		else if (ce) begin
			if (start)
				cnt_q <= CW'(CYCLES);
			else if (cnt_q != '0)
				cnt_q <= cnt_q - 1'b1;
		end
	end

	assign busy = (cnt_q != '0);

endmodule

// File: rtl/nv_array.sv
`timescale 1ns/10ps
module nv_array import flash_seq_pkg::*; #(
	parameter int DEPTH = USER_BIG + VEC_BYTES,
	parameter int IW    = $clog2(DEPTH)
) (
	// Clock and enable.
	input  wire logic          clk,
	input  wire logic          ce,
	// Byte programming.
	input  wire logic          prog_en,
	input  wire logic [IW-1:0] prog_idx,
	input  wire logic [7:0]    prog_data,
	// Page or whole erase.
	input  wire logic          erase_en,
	input  wire logic          erase_mass,
	input  wire logic [IW-1:0] erase_idx,
	// Read port, data one cycle later.
	input  wire logic [IW-1:0] rd_idx,
	output logic [7:0]         rd_data
);

	localparam int PW = $clog2(PAGE_BYTES);

	logic [7:0] mem [DEPTH];

	// Erase drives cells to one, programming can only pull bits to zero.
	always_ff @(posedge clk) begin
		if (ce) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (erase_en && (erase_mass || (IW'(i) >> PW) == (erase_idx >> PW)))
					mem[i] <= ERASED_BYTE;
				else if (prog_en && prog_idx == IW'(i))
					mem[i] <= mem[i] & prog_data;
			end
			rd_data <= mem[rd_idx];
		end
	end

endmodule

// File: rtl/flash_seq.sv
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
// Function
// - Array holds 4096 or 1536 user bytes plus 48 vector bytes.
// - Erase acts on whole 64-byte pages at minimum.
// - One program cycle writes bytes within a single 32-byte row.
// - Vectors fill top 48 bytes; user space ends at FDFF, below the control and protect registers.
// - Erased cells read one, programmed cells read zero.
// - High voltage sets only with program or erase selected, correct order.
// - Mass bit makes erase clear the whole array.
// - Array readable again about 1 us after high voltage clears.
// - Steps keep their order; unrelated bus cycles may come between.
// - Protection runs from a start derived from protect value to top.
// - High voltage refused when target lies in the protected region.
// - Protect zero guards all; all ones guards nothing.
// - Protect not all ones blocks mass erase; protect changes need test high voltage whatever the value.
// - Protect changes only with test high voltage; same level gates monitor entry.
module flash_seq import flash_seq_pkg::*; #(
	parameter int USER_BYTES = USER_BIG,
	parameter int UNIT       = PROT_UNIT
) (
	// Clock, reset and enable.
	input  wire logic     clk,
	input  wire logic     resetn,
	input  wire logic     ce,
	// Register port.
	input  wire bus_req_t req,
	output logic [7:0]    rdata,
	// Test voltage sense and monitor entry.
	input  wire logic     test_high_voltage,
	output logic          monitor_ok,
	// Charge pump control.
	output logic          high_voltage_enable
);

	localparam int          DEPTH   = USER_BYTES + VEC_BYTES;
	localparam int          IW      = $clog2(DEPTH);
	localparam logic [15:0] USER_LO = 16'(32'(USER_HI) + 1 - USER_BYTES);
	localparam int          RW      = $clog2(ROW_BYTES);
	localparam int          PW      = $clog2(PAGE_BYTES);

	initial begin
		if (USER_BYTES != USER_BIG && USER_BYTES != USER_SMALL)
			$error("flash_seq supports only the two documented array sizes");
		if (UNIT < PAGE_BYTES || UNIT % PAGE_BYTES != 0)
			$error("protect unit must be whole pages");
	end

	////////////////////////////////////////////////////////////////////////////
	// Reset release.

	logic [1:0] rst_sync_q;
	logic       rst_n;

	// Two flops so that reset leaves every flop reset by rst_n on the same edge.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	////////////////////////////////////////////////////////////////////////////
	// Address decode.

	logic          in_user;
	logic          in_vec;
	logic          in_arr;
	logic [IW-1:0] idx;
	logic          ctrl_wr;
	logic          ctrl_rd;
	logic          prot_wr;
	logic          prot_rd;
	logic          arr_wr;

	// Vectors pack directly above the user bytes inside the array.
	assign in_user = (req.addr >= USER_LO) && (req.addr <= USER_HI);
	assign in_vec  = (req.addr >= VEC_LO);
	assign in_arr  = in_user || in_vec;
	assign idx     = in_vec ? IW'(16'(req.addr - VEC_LO) + 16'(USER_BYTES))
	                        : IW'(req.addr - USER_LO);
	assign ctrl_wr = req.wr && req.addr == CTRL_ADDR;
	assign ctrl_rd = req.rd && req.addr == CTRL_ADDR;
	assign prot_wr = req.wr && req.addr == PROT_ADDR;
	assign prot_rd = req.rd && req.addr == PROT_ADDR;
	assign arr_wr  = req.wr && in_arr;

	////////////////////////////////////////////////////////////////////////////
	// Protect value and monitor entry.

	logic [7:0] prot_q;
	logic       strap_done_q;
	logic       monitor_q;

	// Only the external test level lets the value change, open or locked alike.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			prot_q <= PROT_OPEN;
		else if (ce && prot_wr && test_high_voltage)
			prot_q <= req.wdata;
	end

	// The test level is caught once, on the first enabled edge after reset.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_done_q <= 1'b0;
			monitor_q    <= 1'b0;
		end else if (ce && !strap_done_q) begin
			strap_done_q <= 1'b1;
			monitor_q    <= test_high_voltage;
		end
	end
	assign monitor_ok = monitor_q;

	// Fixed map from protect value to the first guarded address.
	function automatic logic [16:0] prot_start(input logic [7:0] v);
		prot_start = 17'(USER_LO) + 17'(int'(v) * UNIT);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Control bits and sequence.

	seq_state_t    st_q;
	logic          pgm_q;
	logic          erase_q;
	logic          mass_q;
	logic [15:0]   tgt_q;
	logic          tgt_prot;
	logic          hv_ok;
	logic          hv_go;
	logic          erase_go;
	logic          prog_go;
	logic          rcv_busy;
	logic          sel_any;

	// All zeros starts at the bottom and guards all; all ones opens everything.
	assign tgt_prot = (prot_q != PROT_OPEN)
	               && ({1'b0, tgt_q} >= prot_start(prot_q));
	assign hv_ok    = !tgt_prot && !(erase_q && mass_q && prot_q != PROT_OPEN);
	assign sel_any  = req.wdata[CTRL_PGM] || req.wdata[CTRL_ERASE];
	assign hv_go    = st_q == ST_LATCH && ctrl_wr && req.wdata[CTRL_HV]
	               && (pgm_q || erase_q) && hv_ok;
	assign erase_go = hv_go && erase_q && !pgm_q;
	// Bytes outside the latched row, and the watchdog address, never reach cells.
	assign prog_go  = st_q == ST_HV && pgm_q && arr_wr && req.addr != WDOG_ADDR
	               && req.addr[15:RW] == tgt_q[15:RW];

	// Select bits store on any control write; high voltage is the state itself.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pgm_q   <= CTRL_RESET[CTRL_PGM];
			erase_q <= CTRL_RESET[CTRL_ERASE];
			mass_q  <= CTRL_RESET[CTRL_MASS];
		end else if (ce && ctrl_wr) begin
			pgm_q   <= req.wdata[CTRL_PGM];
			erase_q <= req.wdata[CTRL_ERASE];
			mass_q  <= req.wdata[CTRL_MASS];
		end
	end

	// First array write after the protect read fixes the target.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			tgt_q <= 16'h0000;
		else if (ce && st_q == ST_PROTRD && arr_wr)
			tgt_q <= req.addr;
	end

	// Unrelated cycles leave the state alone, so steps may be spread out.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			st_q <= ST_IDLE;
		else if (ce) begin
			case (st_q)
				ST_IDLE: begin
					if (ctrl_wr && sel_any && !req.wdata[CTRL_HV])
						st_q <= ST_SELECT;
				end
				ST_SELECT: begin
					if (ctrl_wr && !sel_any)
						st_q <= ST_IDLE;
					else if (prot_rd)
						st_q <= ST_PROTRD;
				end
				ST_PROTRD: begin
					if (ctrl_wr && !sel_any)
						st_q <= ST_IDLE;
					else if (arr_wr)
						st_q <= ST_LATCH;
				end
				ST_LATCH: begin
					if (hv_go)
						st_q <= ST_HV;
					else if (ctrl_wr && !sel_any)
						st_q <= ST_IDLE;
				end
				ST_HV: begin
					if (ctrl_wr && !req.wdata[CTRL_HV])
						st_q <= ST_RECOV;
				end
				ST_RECOV: begin
					if (!rcv_busy)
						st_q <= ST_IDLE;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	assign high_voltage_enable = (st_q == ST_HV);

	////////////////////////////////////////////////////////////////////////////
	// Recovery timer and array.

	logic [7:0]    arr_rd;
	logic [IW-1:0] tgt_idx;

	// Array index of the latched target, used to pick the page to erase.
	assign tgt_idx = (tgt_q >= VEC_LO) ? IW'(16'(tgt_q - VEC_LO) + 16'(USER_BYTES))
	                                  : IW'(tgt_q - USER_LO);

	// Loaded when the pump turns off; reads wait for it to run out.
	hold_timer #(
		.CYCLES (RCV_CYCLES)
	) u_rcv (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.start (st_q == ST_HV && ctrl_wr && !req.wdata[CTRL_HV]),
		.busy  (rcv_busy)
	);

	// Erase is taken as done the moment the pump turns on.
	nv_array #(
		.DEPTH (DEPTH),
		.IW    (IW)
	) u_arr (
		.clk        (clk),
		.ce         (ce),
		.prog_en    (prog_go),
		.prog_idx   (idx),
		.prog_data  (req.wdata),
		.erase_en   (erase_go),
		.erase_mass (mass_q),
		.erase_idx  (tgt_idx),
		.rd_idx     (idx),
		.rd_data    (arr_rd)
	);


	////////////////////////////////////////////////////////////////////////////
	// Read data.

	logic [7:0] csr_q;
	logic       arr_sel_q;
	logic       arr_ok;

	assign arr_ok = (st_q != ST_HV) && (st_q != ST_RECOV);

	// Array reads during high voltage or recovery return a fixed busy byte.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			csr_q     <= 8'h00;
			arr_sel_q <= 1'b0;
		end else if (ce) begin
			arr_sel_q <= req.rd && in_arr && arr_ok;
			if (ctrl_rd)
				csr_q <= {arr_ok, 3'b000, high_voltage_enable, mass_q, erase_q, pgm_q};
			else if (prot_rd)
				csr_q <= prot_q;
			else if (req.rd && in_arr)
				csr_q <= BUSY_BYTE;
			else
				csr_q <= 8'h00;
		end
	end
	assign rdata = arr_sel_q ? arr_rd : csr_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	sequence s_selected;
		pgm_q || erase_q;
	endsequence

	sequence s_pump_on;
		$rose(high_voltage_enable);
	endsequence

	AST_HV_NEEDS_SELECT: assert property (@(posedge clk) disable iff (!rst_n)
		s_pump_on |-> $past(pgm_q || erase_q) && $past(st_q == ST_LATCH))
		else $error("pump on without program or erase select");
	AST_HV_NOT_PROTECTED: assert property (@(posedge clk) disable iff (!rst_n)
		s_pump_on |-> !$past(tgt_prot))
		else $error("pump on for a protected target");
	AST_MASS_OPEN_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
		erase_go && mass_q |-> prot_q == 8'hFF)
		else $error("mass erase while protected");
	AST_PROG_IN_ROW: assert property (@(posedge clk) disable iff (!rst_n)
		prog_go |-> high_voltage_enable && req.addr[15:5] == tgt_q[15:5])
		else $error("byte programmed outside latched row");
	AST_NO_WDOG_CELL: assert property (@(posedge clk) disable iff (!rst_n)
		prog_go |-> req.addr != 16'hFFFF)
		else $error("watchdog address reached the array");
	AST_PROT_GUARD: assert property (@(posedge clk) disable iff (!rst_n)
		ce && prot_wr && !test_high_voltage |=> $stable(prot_q))
		else $error("locked protect value changed");
	AST_RECOVERY: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		$fell(high_voltage_enable) |-> (!arr_ok)[*8] ##[1:300] st_q == ST_IDLE)
		else $error("recovery window wrong");
	AST_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(st_q == ST_LATCH) |-> ($past(st_q == ST_PROTRD) and s_selected))
		else $error("target latched out of order");
	AST_ZERO_GUARDS_ALL: assert property (@(posedge clk) disable iff (!rst_n)
		prot_q == 8'h00 && st_q == ST_LATCH |-> !hv_ok)
		else $error("zero protect value left array open");

endmodule

// File: testbench/tb.sv
`timescale 1ns/10ps
// Compares a design value with its expectation and reports a mismatch at once.
`define CHK(got, exp) \
	begin \
		num_checks++; \
		if ((got) !== (exp)) begin \
			errors++; \
			$display("wrong value at %0t ns: got %h expected %h", $time, (got), (exp)); \
		end \
	end

module tb import flash_seq_pkg::*;;

	////////////////////////////////////////////////////////////////////////////
	// Stimulus and observation signals.
	logic       clk;
	logic       resetn;
	logic       ce;
	logic       test_high_voltage;
	bus_req_t   req;
	logic [7:0] rdata;
	logic       monitor_ok;
	logic       high_voltage_enable;
	int         errors;
	int         num_checks;
	logic [7:0] rd_val;

	// Lowest user byte of the large array variant.
	localparam logic [15:0] USER_LO = USER_HI - 16'(USER_BIG) + 16'h0001;

	flash_seq #(
		.USER_BYTES (USER_BIG),
		.UNIT       (PROT_UNIT)
	) dut (
		.clk                 (clk),
		.resetn              (resetn),
		.ce                  (ce),
		.req                 (req),
		.rdata               (rdata),
		.test_high_voltage   (test_high_voltage),
		.monitor_ok          (monitor_ok),
		.high_voltage_enable (high_voltage_enable)
	);

	// Free-running bus clock at 250 MHz.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus and sequence helpers.

	// Holds reset for three edges, then leaves room for the two-flop release.
	task automatic do_reset(input logic tv);
		@(posedge clk);
		resetn            <= 1'b0;
		test_high_voltage <= tv;
		req               <= '0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
	endtask

	// The bench plays the processor, running its sequences from outside the array.
	// One-cycle write strobe; a gap cycle follows so the strobe never toggles twice.
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample there.
	task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic check_rd(input logic [15:0] a, input logic [7:0] exp);
		rd_reg(a, rd_val);
		`CHK(rd_val, exp)
	endtask

	// Select, read protection, latch the target, then ask for the pump.
	task automatic start_seq(input logic [7:0] sel, input logic [15:0] target,
		input logic exp_hv);
		wr_reg(CTRL_ADDR, sel);
		rd_reg(PROT_ADDR, rd_val); // Protect read before the pump.
		wr_reg(target, 8'hFF); // Target latched after the protect read.
		wr_reg(CTRL_ADDR, sel | 8'h08);
		#1;
		`CHK(high_voltage_enable, exp_hv) // Pump follows the sequence.
	endtask

	// Clear the select bits, turn the pump off, then sit out the recovery.
	task automatic end_seq;
		wr_reg(CTRL_ADDR, 8'h08); // Program cleared before the pump; hold is untimed.
		wr_reg(CTRL_ADDR, 8'h00);
		check_rd(USER_LO, BUSY_BYTE); // Array still recovering.
		`CHK(high_voltage_enable, 1'b0) // Pump off.
		repeat (RCV_CYCLES + 4) @(posedge clk);
	endtask

	// One byte through the whole sequence; the watchdog address is never written here.
	task automatic prog_one(input logic [15:0] a, input logic [7:0] d);
		start_seq(8'h01, a, 1'b1); // Open target.
		wr_reg(a, d); // Byte waits are not timed by the hardware, so kept short.
		end_seq();
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Scenarios.

	task automatic t_reset;
		rd_reg(CTRL_ADDR, rd_val);
		`CHK(rd_val & 8'h7F, 8'h00) // Control bits clear after reset.
		@(posedge clk);
		ce <= 1'b0;
		wr_reg(CTRL_ADDR, 8'h01); // Write while frozen.
		ce <= 1'b1;
		rd_reg(CTRL_ADDR, rd_val);
		`CHK(rd_val & 8'h7F, 8'h00) // Frozen enable drops the select write.
		check_rd(PROT_ADDR, PROT_OPEN); // Whole array open.
		check_rd(16'h0010, 8'h00); // Unmapped location.
		`CHK(monitor_ok, 1'b0) // No test voltage at reset.
	endtask

	// Mass erase clears user space and vectors alike; control shows the pump.
	task automatic t_mass_erase;
		start_seq(8'h06, USER_LO, 1'b1); // Mass erase allowed when open.
		rd_reg(CTRL_ADDR, rd_val);
		`CHK(rd_val[3:0], 4'hE) // Pump, mass and erase bits read back.
		end_seq();
		check_rd(USER_LO, ERASED_BYTE); // Bottom of user space.
		check_rd(USER_HI, ERASED_BYTE); // Top of user space.
		check_rd(VEC_LO, ERASED_BYTE); // Vector space erased too.
		check_rd(WDOG_ADDR, ERASED_BYTE); // Highest address.
	endtask

	// Row program with an interleaved read and a stray write into another row.
	task automatic t_program;
		start_seq(8'h01, USER_LO, 1'b1); // Program sequence.
		wr_reg(USER_LO, 8'hA5);
		rd_reg(CTRL_ADDR, rd_val);
		wr_reg(USER_LO + 16'h0001, 8'h3C);
		wr_reg(USER_LO + 16'h0020, 8'h00);
		end_seq();
		check_rd(USER_LO, 8'hA5); // First byte of the row.
		check_rd(USER_LO + 16'h0001, 8'h3C); // Second byte of the row.
		check_rd(USER_LO + 16'h0020, ERASED_BYTE); // Other row untouched.
		prog_one(USER_LO, 8'h0F);
		check_rd(USER_LO, 8'h05); // Programming only clears bits.
		prog_one(VEC_LO, 8'h81);
		check_rd(VEC_LO, 8'h81); // Lowest vector byte.
	endtask

	// Page erase clears its 64 bytes and leaves the next page alone.
	task automatic t_page_erase;
		prog_one(USER_LO + 16'h0040, 8'h5A);
		start_seq(8'h02, USER_LO + 16'h0005, 1'b1); // Page erase.
		end_seq();
		check_rd(USER_LO, ERASED_BYTE); // Page start.
		check_rd(USER_LO + 16'h003F, ERASED_BYTE); // Page end.
		check_rd(USER_LO + 16'h0040, 8'h5A); // Next page kept.
	endtask

	// Pump requests out of order must be ignored.
	task automatic t_order;
		wr_reg(CTRL_ADDR, 8'h08);
		#1;
		`CHK(high_voltage_enable, 1'b0) // Nothing selected.
		wr_reg(CTRL_ADDR, 8'h01);
		wr_reg(USER_LO, 8'hFF);
		wr_reg(CTRL_ADDR, 8'h09);
		#1;
		`CHK(high_voltage_enable, 1'b0) // Protection never read.
		wr_reg(CTRL_ADDR, 8'h00);
	endtask

	// Protect value changes and the protected range it defines.
	task automatic t_protect;
		wr_reg(PROT_ADDR, 8'h00);
		check_rd(PROT_ADDR, PROT_OPEN); // Change refused without test voltage.
		@(posedge clk);
		test_high_voltage <= 1'b1;
		wr_reg(PROT_ADDR, 8'h08);
		check_rd(PROT_ADDR, 8'h08); // Change taken with test voltage.
		@(posedge clk);
		test_high_voltage <= 1'b0;
		wr_reg(PROT_ADDR, 8'hFF);
		check_rd(PROT_ADDR, 8'h08); // Still refused without test voltage, set or open alike.
		start_seq(8'h01, USER_LO + 16'h0200, 1'b0); // First protected byte.
		wr_reg(CTRL_ADDR, 8'h00);
		start_seq(8'h01, VEC_LO, 1'b0); // Protection reaches the top.
		wr_reg(CTRL_ADDR, 8'h00);
		start_seq(8'h06, USER_LO, 1'b0); // Mass erase blocked.
		wr_reg(CTRL_ADDR, 8'h00);
		start_seq(8'h01, USER_LO + 16'h01FF, 1'b1); // Last open byte.
		end_seq();
		@(posedge clk);
		test_high_voltage <= 1'b1;
		wr_reg(PROT_ADDR, 8'h00);
		@(posedge clk);
		test_high_voltage <= 1'b0;
		start_seq(8'h01, USER_LO, 1'b0); // Zero guards everything.
		wr_reg(CTRL_ADDR, 8'h00);
	endtask

	// A reset with the test voltage present enables monitor entry.
	task automatic t_monitor;
		do_reset(1'b1);
		#1;
		`CHK(monitor_ok, 1'b1) // Test voltage seen at reset.
		check_rd(PROT_ADDR, PROT_OPEN); // Protection back to open.
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Verdict, main sequence and hang guard.

	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Clock enable starts high; only t_reset drops it, for one frozen write.
	initial begin
		resetn            = 1'b0;
		ce                = 1'b1;
		test_high_voltage = 1'b0;
		req               = '0;
		errors            = 0;
		num_checks        = 0;
		do_reset(1'b0);
		t_reset();
		t_mass_erase();
		t_program();
		t_page_erase();
		t_order();
		t_protect();
		t_monitor();
		give_verdict();
	end

	// A run far beyond the expected length counts as a mismatch.
	initial begin
		#100000;
		errors++;
		$display("timeout at %0t ns", $time);
		give_verdict();
	end

endmodule
